// [design/chgcr_i2c_slave.sv]
`timescale 1ns/1ps
`default_nettype none
module chgcr_i2c_slave (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_oe,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata,
  input wire logic [7:0] i_rdata,
  input wire logic i_addr_ok
);
  typedef enum logic [2:0] {
    S_IDLE, S_DEVADR, S_REGADR, S_WDATA, S_RDATA, S_ACK, S_RACK
  } chgcr_i2c_st_t;

  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic scl_d;
    logic sda_d;
    chgcr_i2c_st_t st;
    chgcr_i2c_st_t after_ack;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic rnw;
    logic oe;
    logic ack_nack;
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } chgcr_i2c_t;

  chgcr_i2c_t s_r;
  chgcr_i2c_t s_nxt;

  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;

  assign scl_rise = s_r.scl_s[1] & ~s_r.scl_d;
  assign scl_fall = ~s_r.scl_s[1] & s_r.scl_d;
  assign start_c = s_r.scl_s[1] & s_r.scl_d & s_r.sda_d & ~s_r.sda_s[1];
  assign stop_c = s_r.scl_s[1] & s_r.scl_d & ~s_r.sda_d & s_r.sda_s[1];

  always_comb begin
    s_nxt = s_r;
    s_nxt.scl_s = {s_r.scl_s[0], i_scl};
    s_nxt.sda_s = {s_r.sda_s[0], i_sda};
    s_nxt.scl_d = s_r.scl_s[1];
    s_nxt.sda_d = s_r.sda_s[1];
    s_nxt.wr = 1'b0;
    s_nxt.rd = 1'b0;
    if (stop_c) begin
      s_nxt.st = S_IDLE;
      s_nxt.oe = 1'b0;
    end else if (start_c) begin
      s_nxt.st = S_DEVADR;
      s_nxt.bitn = 4'h0;
      s_nxt.oe = 1'b0;
    end else begin
      unique case (s_r.st)
        S_IDLE: s_nxt.oe = 1'b0;
        S_DEVADR, S_REGADR, S_WDATA: begin
          if (scl_rise) begin
            s_nxt.sh = {s_r.sh[6:0], s_r.sda_s[1]};
            s_nxt.bitn = s_r.bitn + 4'h1;
          end
          if (scl_fall && s_r.bitn == 4'h8) begin
            s_nxt.bitn = 4'h0;
            s_nxt.st = S_ACK;
            s_nxt.oe = 1'b1;
            s_nxt.ack_nack = 1'b0;
            if (s_r.st == S_DEVADR) begin
              s_nxt.rnw = s_r.sh[0];
              if (s_r.sh[7:1] != chgcr_pkg::SLAVE_ADDR) begin
                s_nxt.oe = 1'b0;
                s_nxt.st = S_IDLE;
              end else if (s_r.sh[0]) begin
                s_nxt.after_ack = S_RDATA;
                s_nxt.rd = 1'b1;
              end else begin
                s_nxt.after_ack = S_REGADR;
              end
            end else if (s_r.st == S_REGADR) begin
              s_nxt.addr = s_r.sh;
              s_nxt.after_ack = S_WDATA;
            end else begin
              // Undefined register: NACK, then back to idle
              if (i_addr_ok) begin
                s_nxt.wdata = s_r.sh;
                s_nxt.wr = 1'b1;
                s_nxt.after_ack = S_WDATA;
              end else begin
                s_nxt.oe = 1'b0;
                s_nxt.st = S_IDLE;
              end
            end
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            s_nxt.oe = 1'b0;
            s_nxt.st = s_r.after_ack;
            if (s_r.after_ack == S_RDATA) begin
              s_nxt.sh = i_rdata;
              s_nxt.oe = ~i_rdata[7];
              s_nxt.bitn = 4'h1;
            end
          end
        end
        S_RDATA: begin
          if (scl_fall) begin
            if (s_r.bitn == 4'h8) begin
              s_nxt.oe = 1'b0;
              s_nxt.st = S_RACK;
            end else begin
              s_nxt.oe = ~s_r.sh[7 - s_r.bitn[2:0]];
              s_nxt.bitn = s_r.bitn + 4'h1;
            end
          end
        end
        S_RACK: begin
          if (scl_rise) begin
            s_nxt.ack_nack = s_r.sda_s[1];
            // Step early so next byte's data is ready at the fall
            if (!s_r.sda_s[1]) begin
              s_nxt.addr = s_r.addr + 8'h01;
            end
          end
          if (scl_fall) begin
            if (s_r.ack_nack) begin
              s_nxt.st = S_IDLE;
            end else begin
              // Multi-read: first bit must go out at this very fall
              s_nxt.sh = i_rdata;
              s_nxt.oe = ~i_rdata[7];
              s_nxt.bitn = 4'h1;
              s_nxt.rd = 1'b1;
              s_nxt.st = S_RDATA;
            end
          end
        end
        default: s_nxt.st = S_IDLE;
      endcase
      if (s_r.wr) begin
        s_nxt.addr = s_r.addr + 8'h01;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_r <= '{scl_s: 2'h3, sda_s: 2'h3, scl_d: 1'b1, sda_d: 1'b1,
               st: S_IDLE, after_ack: S_IDLE, bitn: 4'h0, sh: 8'h00,
               rnw: 1'b0, oe: 1'b0, ack_nack: 1'b0, wr: 1'b0, rd: 1'b0,
               addr: 8'h00, wdata: 8'h00};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_sda_oe = s_r.oe;
  assign o_wr = s_r.wr;
  assign o_rd = s_r.rd;
  assign o_addr = s_r.addr;
  assign o_wdata = s_r.wdata;
endmodule : chgcr_i2c_slave
`default_nettype wire

// [design/chgcr_pkg.sv]
// Notes on behaviour
// - Bit 7 of input control enables high-impedance input mode; reset 0.
// - Status pin function code 11 floats the pin; codes 01 and 10 reserved.
// - Input limit is a 5-bit code, 100 mA offset, weights 100 to 1600 mA.
// - Input limit resets to code 10111 (2400 mA), a maximum, not typical.
// - After detection the limit becomes 500 mA (select high) or 2.4 A.
// - Writing 1 to bit 6 of power-on config kicks the watchdog; self-clears.
// - Boost enable (bit 5, reset 0) overrides charge enable.
// - Charging needs the enable pin low and the charge enable bit (reset 1).
// - The 3-bit floor code maps 000..111 to 2.6..3.7 V; reset code 101.
// - Cutoff bit picks 2.8 V falling (0, reset) or 2.5 V; rising is 3.0 V.
// - Reg reset restores all; watchdog: hi-Z, kick, boost, charge enable.
// - Answers as I2C slave at 7-bit address 6BH for register access.
package chgcr_pkg;
  localparam logic [6:0] SLAVE_ADDR = 7'h6B;
  localparam logic [7:0] OFS_INPUT_CONTROL = 8'h00;
  localparam logic [7:0] OFS_POWER_ON_CONFIG = 8'h01;
  localparam logic [7:0] UNMAPPED_READ = 8'hFF;
  localparam int HIZ_BIT = 7;
  localparam int STAT_FN_LSB = 5;
  localparam int ILIM_LSB = 0;
  localparam int SKIP_DIS_BIT = 7;
  localparam int KICK_BIT = 6;
  localparam int BOOST_BIT = 5;
  localparam int CHG_BIT = 4;
  localparam int FLOOR_LSB = 1;
  localparam int CUTOFF_BIT = 0;
  localparam logic [7:0] INPUT_CONTROL_RST = 8'h17;
  localparam logic [7:0] POWER_ON_CONFIG_RST = 8'h1A;
  localparam logic [1:0] STAT_FN_FLOAT = 2'h3;
  localparam logic [4:0] ILIM_RST = 5'h17;
  localparam logic [4:0] ILIM_SEL_HIGH = 5'h04;
  localparam logic [4:0] ILIM_SEL_LOW = 5'h17;
  localparam logic [2:0] FLOOR_RST = 3'h5;
  localparam int ILIM_OFFSET_MA = 100;
  localparam int ILIM_STEP_MA = 100;
  // Floor voltages in mV, indexed by code
  localparam logic [11:0] FLOOR_MV [8] = '{12'hA28, 12'hAF0, 12'hBB8,
    12'hC80, 12'hD48, 12'hDAC, 12'hE10, 12'hE74};
  localparam logic [11:0] CUTOFF_FALL_0_MV = 12'hAF0;
  localparam logic [11:0] CUTOFF_FALL_1_MV = 12'h9C4;
  localparam logic [11:0] CUTOFF_RISE_MV = 12'hBB8;
  localparam int SYNC_STAGES = 2;
endpackage : chgcr_pkg

// [design/chgcr_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module chgcr_regs (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_oe,
  output logic o_sda_out,
  output logic o_scl_oe,
  output logic o_scl_out,
  input wire logic i_src_sel,
  input wire logic i_detect_done,
  input wire logic i_charge_enable_n,
  input wire logic i_reg_reset,
  input wire logic i_wdog_expired,
  output logic o_wdog_kick,
  output logic o_high_impedance_enable,
  output logic o_status_pin_float,
  output logic [4:0] o_input_current_limit,
  output logic o_light_load_pulse_skip_disable,
  output logic o_boost_on,
  output logic o_charge_on,
  output logic [2:0] o_system_voltage_floor,
  output logic [11:0] o_floor_mv,
  output logic [11:0] o_cutoff_fall_mv,
  output logic [11:0] o_cutoff_rise_mv,
  output logic [7:0] o_input_control,
  output logic [7:0] o_power_on_config
);
  typedef struct packed {
    logic [7:0] input_control;
    logic [7:0] power_on_config;
    logic [1:0] pins_s0;
    logic [1:0] pins_s1;
    logic det_d;
    logic kick;
  } chgcr_st_t;

  chgcr_st_t s_r;
  chgcr_st_t s_nxt;

  logic bus_wr;
  logic [7:0] bus_addr;
  logic [7:0] bus_wdata;
  logic [7:0] bus_rdata;
  logic addr_ok;
  logic src_sel_q;
  logic ce_n_q;

  chgcr_i2c_slave u_slave (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .o_sda_oe(o_sda_oe),
    .o_wr(bus_wr),
    .o_rd(),
    .o_addr(bus_addr),
    .o_wdata(bus_wdata),
    .i_rdata(bus_rdata),
    .i_addr_ok(addr_ok)
  );

  assign src_sel_q = s_r.pins_s1[0];
  assign ce_n_q = s_r.pins_s1[1];
  assign addr_ok = (bus_addr == chgcr_pkg::OFS_INPUT_CONTROL) ||
                   (bus_addr == chgcr_pkg::OFS_POWER_ON_CONFIG);

  always_comb begin
    unique case (bus_addr)
      chgcr_pkg::OFS_INPUT_CONTROL: bus_rdata = s_r.input_control;
      chgcr_pkg::OFS_POWER_ON_CONFIG: bus_rdata = s_r.power_on_config;
      default: bus_rdata = chgcr_pkg::UNMAPPED_READ;
    endcase
  end

  always_comb begin
    s_nxt = s_r;
    // Source select and enable pins pass two flops first
    s_nxt.pins_s0 = {i_charge_enable_n, i_src_sel};
    s_nxt.pins_s1 = s_r.pins_s0;
    s_nxt.det_d = i_detect_done;
    s_nxt.kick = 1'b0;
    // Kick bit clears itself one cycle after the write
    s_nxt.power_on_config[chgcr_pkg::KICK_BIT] = 1'b0;
    if (bus_wr && bus_addr == chgcr_pkg::OFS_INPUT_CONTROL) begin
      s_nxt.input_control = bus_wdata;
    end
    if (bus_wr && bus_addr == chgcr_pkg::OFS_POWER_ON_CONFIG) begin
      s_nxt.power_on_config = bus_wdata;
      s_nxt.kick = bus_wdata[chgcr_pkg::KICK_BIT];
    end
    // Detection wins over a same-cycle host write; host may rewrite later
    if (i_detect_done && !s_r.det_d) begin
      s_nxt.input_control[chgcr_pkg::ILIM_LSB +: 5] = src_sel_q ?
        chgcr_pkg::ILIM_SEL_HIGH : chgcr_pkg::ILIM_SEL_LOW;
    end
    if (i_wdog_expired) begin
      s_nxt.input_control[chgcr_pkg::HIZ_BIT] = 1'b0;
      s_nxt.power_on_config[chgcr_pkg::KICK_BIT] = 1'b0;
      s_nxt.power_on_config[chgcr_pkg::BOOST_BIT] = 1'b0;
      s_nxt.power_on_config[chgcr_pkg::CHG_BIT] = 1'b1;
    end
    if (i_reg_reset) begin
      s_nxt.input_control = chgcr_pkg::INPUT_CONTROL_RST;
      s_nxt.power_on_config = chgcr_pkg::POWER_ON_CONFIG_RST;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_r <= '{input_control: chgcr_pkg::INPUT_CONTROL_RST,
               power_on_config: chgcr_pkg::POWER_ON_CONFIG_RST,
               pins_s0: 2'h3, pins_s1: 2'h3, det_d: 1'b0, kick: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_sda_out = 1'b0;
  assign o_scl_oe = 1'b0;
  assign o_scl_out = 1'b0;
  assign o_wdog_kick = s_r.kick;
  assign o_input_control = s_r.input_control;
  assign o_power_on_config = s_r.power_on_config;
  assign o_high_impedance_enable = s_r.input_control[chgcr_pkg::HIZ_BIT];
  assign o_status_pin_float =
    s_r.input_control[chgcr_pkg::STAT_FN_LSB +: 2] ==
    chgcr_pkg::STAT_FN_FLOAT;
  assign o_input_current_limit = s_r.input_control[chgcr_pkg::ILIM_LSB +: 5];
  assign o_light_load_pulse_skip_disable =
    s_r.power_on_config[chgcr_pkg::SKIP_DIS_BIT];
  assign o_boost_on = s_r.power_on_config[chgcr_pkg::BOOST_BIT];
  assign o_charge_on = ~ce_n_q &
    s_r.power_on_config[chgcr_pkg::CHG_BIT] &
    ~s_r.power_on_config[chgcr_pkg::BOOST_BIT];
  assign o_system_voltage_floor =
    s_r.power_on_config[chgcr_pkg::FLOOR_LSB +: 3];
  assign o_floor_mv =
    chgcr_pkg::FLOOR_MV[s_r.power_on_config[chgcr_pkg::FLOOR_LSB +: 3]];
  assign o_cutoff_fall_mv = s_r.power_on_config[chgcr_pkg::CUTOFF_BIT] ?
    chgcr_pkg::CUTOFF_FALL_1_MV : chgcr_pkg::CUTOFF_FALL_0_MV;
  assign o_cutoff_rise_mv = chgcr_pkg::CUTOFF_RISE_MV;
endmodule : chgcr_regs
`default_nettype wire

// [tb/chgcr_host.sv]
`timescale 1ns/1ps
`default_nettype none
module chgcr_host (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda
);
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // Eight clocks a phase, slow against the pin synchronisers
  task automatic hw(input logic c, input logic d);
    repeat (8) @(posedge i_clk);
    o_scl <= c;
    o_sda <= d;
  endtask : hw
  task automatic start();
    hw(1'b0, 1'b1);
    hw(1'b1, 1'b1);
    hw(1'b1, 1'b0);
    hw(1'b0, 1'b0);
  endtask : start
  task automatic stop();
    hw(1'b0, 1'b0);
    hw(1'b1, 1'b0);
    hw(1'b1, 1'b1);
  endtask : stop
  // Eight bits and the acknowledge slot; 1 releases the line
  task automatic xfer(input logic [8:0] d, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      hw(1'b0, d[i]);
      hw(1'b1, d[i]);
      repeat (8) @(posedge i_clk);
      r[i] = i_sda;
    end
  endtask : xfer
  task automatic wr(input logic [6:0] dev, input logic [7:0] a,
    input logic [7:0] v, output logic ok);
    logic [8:0] r0;
    logic [8:0] r1;
    logic [8:0] r2;
    start();
    xfer({dev, 2'b01}, r0);
    xfer({a, 1'b1}, r1);
    xfer({v, 1'b1}, r2);
    stop();
    ok = !(r0[0] | r1[0] | r2[0]);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    logic [8:0] r;
    start();
    xfer({chgcr_pkg::SLAVE_ADDR, 2'b01}, r);
    xfer({a, 1'b1}, r);
    start();
    xfer({chgcr_pkg::SLAVE_ADDR, 2'b11}, r);
    xfer(9'h1FF, r);
    stop();
    q = r[8:1];
  endtask : rd
  // Two bytes in one read; the first is acknowledged by the host
  task automatic rd2(input logic [7:0] a, output logic [15:0] q);
    logic [8:0] r;
    logic [8:0] s;
    start();
    xfer({chgcr_pkg::SLAVE_ADDR, 2'b01}, r);
    xfer({a, 1'b1}, r);
    start();
    xfer({chgcr_pkg::SLAVE_ADDR, 2'b11}, r);
    xfer(9'h1FE, r);
    xfer(9'h1FF, s);
    stop();
    q = {r[8:1], s[8:1]};
  endtask : rd2
endmodule : chgcr_host
`default_nettype wire

// [tb/chgcr_regs_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module chgcr_regs_asserts (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_src_sel,
  input wire logic i_detect_done,
  input wire logic i_charge_enable_n,
  input wire logic i_reg_reset,
  input wire logic i_wdog_expired,
  input wire logic o_wdog_kick,
  input wire logic o_high_impedance_enable,
  input wire logic o_status_pin_float,
  input wire logic [4:0] o_input_current_limit,
  input wire logic o_boost_on,
  input wire logic o_charge_on,
  input wire logic [11:0] o_floor_mv,
  input wire logic [11:0] o_cutoff_fall_mv,
  input wire logic [7:0] o_input_control,
  input wire logic [7:0] o_power_on_config
);
  localparam logic [11:0] MV [8] = '{12'hA28, 12'hAF0, 12'hBB8,
    12'hC80, 12'hD48, 12'hDAC, 12'hE10, 12'hE74};
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  AST_FIELDS: assert property (
    o_high_impedance_enable == o_input_control[7] &&
    o_input_current_limit == o_input_control[4:0]) else $error("field map");
  AST_STAT: assert property (o_status_pin_float ==
    (o_input_control[6:5] == 2'h3)) else $error("status float wrong");
  AST_DETECT: assert property (
    $rose(i_detect_done) && !i_reg_reset && i_src_sel == $past(i_src_sel, 3)
    |-> ##[1:2] o_input_current_limit == (i_src_sel ? 5'h04 : 5'h17))
    else $error("auto limit wrong");
  AST_KICK: assert property ($rose(o_wdog_kick) |=>
    !o_wdog_kick && !o_power_on_config[6]) else $error("kick not cleared");
  AST_BOOST: assert property (o_boost_on |->
    !o_charge_on && o_power_on_config[5]) else $error("boost override");
  AST_CHG_ON: assert property (
    (!i_charge_enable_n)[*4] ##0 o_power_on_config[5:4] == 2'b01
    |-> o_charge_on) else $error("charge not on");
  AST_CHG_OFF: assert property (i_charge_enable_n[*4]
    |-> !o_charge_on) else $error("charge on with pin high");
  AST_DECODE: assert property (
    o_floor_mv == MV[o_power_on_config[3:1]] && o_cutoff_fall_mv ==
    (o_power_on_config[0] ? 12'h9C4 : 12'hAF0)) else $error("decode");
  AST_WDOG: assert property (i_wdog_expired && !i_reg_reset |=>
    !o_input_control[7] && o_power_on_config[6:4] == 3'b001 &&
    o_input_control[6:0] == $past(o_input_control[6:0]))
    else $error("watchdog reset wrong");
  AST_REGRST: assert property (i_reg_reset |=>
    o_input_control == 8'h17 && o_power_on_config == 8'h1A)
    else $error("register reset wrong");
  cover property ($rose(i_detect_done));
  cover property (i_wdog_expired);
  cover property (o_wdog_kick);
endmodule : chgcr_regs_asserts
bind chgcr_regs chgcr_regs_asserts chk_u (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_src_sel(i_src_sel),
  .i_detect_done(i_detect_done), .i_charge_enable_n(i_charge_enable_n),
  .i_reg_reset(i_reg_reset), .i_wdog_expired(i_wdog_expired),
  .o_wdog_kick(o_wdog_kick),
  .o_high_impedance_enable(o_high_impedance_enable),
  .o_status_pin_float(o_status_pin_float),
  .o_input_current_limit(o_input_current_limit), .o_boost_on(o_boost_on),
  .o_charge_on(o_charge_on), .o_floor_mv(o_floor_mv),
  .o_cutoff_fall_mv(o_cutoff_fall_mv), .o_input_control(o_input_control),
  .o_power_on_config(o_power_on_config));
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk;
  logic resetn;
  logic src_sel;
  logic det;
  logic ce_n;
  logic rrst;
  logic wdx;
  logic h_scl;
  logic h_sda;
  logic sda_oe;
  logic scl_oe;
  logic kick;
  logic flt;
  logic boost;
  logic chg;
  logic [11:0] fmv;
  logic [11:0] cfall;
  logic [11:0] crise;
  logic [7:0] q;
  logic [15:0] q2;
  logic hiz;
  logic skip;
  logic [4:0] ilim;
  logic [2:0] flo;
  logic ok;
  int errors = 0;
  int n_tests = 0;
  int kicks = 0;
  logic [11:0] mv [8] = '{12'hA28, 12'hAF0, 12'hBB8, 12'hC80,
    12'hD48, 12'hDAC, 12'hE10, 12'hE74};
  // Open-drain bus with pull-ups
  wire logic scl = h_scl & !scl_oe;
  wire logic sda = h_sda & !sda_oe;
  chgcr_host host_u (.i_clk(clk), .i_sda(sda), .o_scl(h_scl), .o_sda(h_sda));
  chgcr_regs dut_u (
    .i_clk(clk), .i_resetn(resetn), .i_scl(scl), .i_sda(sda),
    .o_sda_oe(sda_oe), .o_sda_out(), .o_scl_oe(scl_oe), .o_scl_out(),
    .i_src_sel(src_sel), .i_detect_done(det), .i_charge_enable_n(ce_n),
    .i_reg_reset(rrst), .i_wdog_expired(wdx), .o_wdog_kick(kick),
    .o_high_impedance_enable(hiz), .o_status_pin_float(flt),
    .o_input_current_limit(ilim), .o_light_load_pulse_skip_disable(skip),
    .o_boost_on(boost), .o_charge_on(chg), .o_system_voltage_floor(flo),
    .o_floor_mv(fmv), .o_cutoff_fall_mv(cfall), .o_cutoff_rise_mv(crise),
    .o_input_control(), .o_power_on_config());
  always @(posedge clk) if (kick === 1'b1) kicks <= kicks + 1;
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    host_u.rd(a, q);
    chk({4'h0, q}, {4'h0, exp});
  endtask : rdc
  task automatic wrc(input logic [7:0] a, input logic [7:0] v,
    input logic ack);
    host_u.wr(chgcr_pkg::SLAVE_ADDR, a, v, ok);
    chk({11'h0, ok}, {11'h0, ack});
  endtask : wrc
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Whole run is near 23k cycles; the limit is about twice that
  initial begin
    #250000;
    errors++;
    stop_test();
  end
  initial begin
    {resetn, src_sel, det, ce_n, rrst, wdx} = 6'h00;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    rdc(8'h00, 8'h17);
    rdc(8'h01, 8'h1A);
    chk(fmv, 12'hDAC);
    chk({11'h0, chg}, 12'h001);
    chk(cfall, 12'hAF0);
    chk(crise, 12'hBB8);
    chk({7'h0, ilim}, 12'h017);
    wrc(8'h00, 8'hE5, 1'b1);
    rdc(8'h00, 8'hE5);
    chk({11'h0, flt}, 12'h001);
    chk({11'h0, hiz}, 12'h001);
    chk({7'h0, ilim}, 12'h005);
    wrc(8'h01, 8'hF1, 1'b1);
    rdc(8'h01, 8'hB1);
    chk(kicks[11:0], 12'h001);
    chk({10'h0, boost, chg}, 12'h002);
    chk(cfall, 12'h9C4);
    @(posedge clk) wdx <= 1'b1;
    @(posedge clk) wdx <= 1'b0;
    rdc(8'h00, 8'h65);
    chk({11'h0, hiz}, 12'h000);
    rdc(8'h01, 8'h91);
    for (int c = 0; c < 8; c++) begin
      wrc(8'h01, {4'h1, c[2:0], 1'b0}, 1'b1);
      chk(fmv, mv[c]);
      chk({9'h0, flo}, {9'h0, c[2:0]});
    end
    @(posedge clk) ce_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk({11'h0, chg}, 12'h000);
    src_sel <= 1'b1;
    repeat (4) @(posedge clk);
    det <= 1'b1;
    repeat (4) @(posedge clk);
    rdc(8'h00, 8'h64);
    chk({7'h0, ilim}, 12'h004);
    wrc(8'h00, 8'h0A, 1'b1);
    rdc(8'h00, 8'h0A);
    @(posedge clk) {det, src_sel} <= 2'b00;
    repeat (4) @(posedge clk);
    det <= 1'b1;
    repeat (4) @(posedge clk);
    rdc(8'h00, 8'h17);
    det <= 1'b0;
    host_u.wr(7'h35, 8'h00, 8'hFF, ok);
    chk({11'h0, ok}, 12'h000);
    rdc(8'h00, 8'h17);
    wrc(8'h0C, 8'h00, 1'b0);
    rdc(8'h0C, 8'hFF);
    wrc(8'h01, 8'hA3, 1'b1);
    chk({11'h0, skip}, 12'h001);
    @(posedge clk) rrst <= 1'b1;
    @(posedge clk) rrst <= 1'b0;
    rdc(8'h01, 8'h1A);
    chk({11'h0, skip}, 12'h000);
    host_u.rd2(8'h00, q2);
    chk({4'h0, q2[15:8]}, 12'h017);
    chk({4'h0, q2[7:0]}, 12'h01A);
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
